// ---- logic/wdtp_pkg.sv ----
// Behaviour
// RL1 - A 15-bit down counter steps on the CPU clock divided by a prescaler.
// RL2 - Underflow raises an interrupt or a watchdog reset, per the underflow action bit.
// RL3 - The underflow action bit can only be set; writing zero never clears it.
// RL4 - With main, oscillator or PLL CPU clock, prescaler divides by 16 or 128.
// RL5 - With the sub clock as CPU clock the prescaler always divides by 2.
// RL6 - Period equals prescaler ratio times 32768 counter steps in CPU clocks.
// RL7 - Any start register write reloads the counter and starts it if idle.
// RL8 - Reset clears the prescaler; counter and prescaler idle until first start write.
// RL9 - Stop, wait and hold freeze counter and prescaler; counting resumes from held value.
// RL10 - Control register returns upper counter bits, read-only, in bits 4 to 0.
// RL11 - Protective mode clocks the counter from the on-chip oscillator.
// RL12 - Software unlocks, sets reset action, sets oscillator source, relocks, then starts.
// RL13 - Protective mode period is 32768 oscillator clocks with no prescaler.
// RL14 - Setting the oscillator source bit starts the oscillator and switches the count clock.
// RL15 - In protective mode writes to the stop mode request bit are ignored.
// RL16 - In protective mode the counter keeps counting through wait and hold.
// RL17 - Software writes zero to the two reserved control register bits.
// RL18 - Each start write reloads all ones; the prescaler runs freely between writes.
package wdtp_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          CNT_W           = 15;
  localparam int          PRE_W           = 7;
  // Printed register offsets are word indices; byte address is four times the index
  localparam logic [5:0]  IDX_START       = 6'h0E;
  localparam logic [5:0]  IDX_CTRL        = 6'h0F;
  localparam logic [5:0]  IDX_PROT        = 6'h10;
  localparam logic [5:0]  IDX_PM_ONE      = 6'h11;
  localparam logic [5:0]  IDX_PM_TWO      = 6'h12;
  localparam logic [5:0]  IDX_CM_ONE      = 6'h13;
  localparam logic [5:0]  IDX_IRQ_STAT    = 6'h14;
  localparam logic [5:0]  IDX_IRQ_MASK    = 6'h15;
  localparam logic [7:0]  ADDR_START      = {IDX_START, 2'b00};
  localparam logic [7:0]  ADDR_CTRL       = {IDX_CTRL, 2'b00};
  localparam logic [7:0]  ADDR_PROT       = {IDX_PROT, 2'b00};
  localparam logic [7:0]  ADDR_PM_ONE     = {IDX_PM_ONE, 2'b00};
  localparam logic [7:0]  ADDR_PM_TWO     = {IDX_PM_TWO, 2'b00};
  localparam logic [7:0]  ADDR_CM_ONE     = {IDX_CM_ONE, 2'b00};
  localparam logic [7:0]  ADDR_IRQ_STAT   = {IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0]  ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};
  // Field positions
  localparam int          CTRL_CNT_LSB    = 0;
  localparam int          CTRL_RSV_LSB    = 5;
  localparam int          CTRL_PRESEL_BIT = 7;
  localparam int          UNLOCK_BIT      = 1;
  localparam int          ACTION_BIT      = 2;
  localparam int          OSCSRC_BIT      = 2;
  localparam int          STOPREQ_BIT     = 0;
  localparam int          IRQ_UFLOW_BIT   = 0;
  // Reset values and counts
  localparam logic [CNT_W-1:0] CNT_RELOAD = 15'h7FFF;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 15'h0000;
  localparam logic [PRE_W-1:0] PRE_RESET  = 7'h00;
  localparam logic [PRE_W-1:0] PRE_TC_16  = 7'h0F;
  localparam logic [PRE_W-1:0] PRE_TC_128 = 7'h7F;
  localparam logic [PRE_W-1:0] PRE_TC_2   = 7'h01;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : wdtp_pkg

// ---- logic/wdtp_core.sv ----
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module wdtp_core (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Chip clock and power state
  input  wire logic        cpu_sub_clock_sel,
  input  wire logic        cpu_clk_run,
  input  wire logic        wait_mode,
  input  wire logic        hold_state,
  input  wire logic        stop_wake,
  input  wire logic        osc_clk_in,
  // Watchdog outputs
  output logic             wdt_reset_req,
  output logic             irq,
  output logic             osc_enable,
  output logic             stop_mode_req
);
  logic                    aw_held_reg;
  logic                    w_held_reg;
  logic [7:0]              aw_addr_reg;
  logic [31:0]             w_data_reg;
  logic [3:0]              w_strb_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    rvalid_reg;
  logic [31:0]             rdata_reg;
  logic [1:0]              rresp_reg;
  logic                    active_reg;
  logic [wdtp_pkg::CNT_W-1:0] cnt_reg;
  logic [wdtp_pkg::PRE_W-1:0] pre_reg;
  logic                    presel_reg;
  logic [1:0]              rsv_reg;
  logic                    unlock_reg;
  logic                    action_reg;
  logic                    oscsrc_reg;
  logic                    stopreq_reg;
  logic                    stat_reg;
  logic                    mask_reg;
  logic                    wdt_reset_reg;
  logic                    osc_s1_reg;
  logic                    osc_s2_reg;
  logic                    osc_s3_reg;
  logic                    wr_do;
  logic                    wr_lane0;
  logic [7:0]              wr_byte;
  logic                    wr_start;
  logic                    wr_ctrl;
  logic                    wr_prot;
  logic                    wr_pm_one;
  logic                    wr_pm_two;
  logic                    wr_cm_one;
  logic                    wr_stat;
  logic                    wr_mask;
  logic                    wr_hit;
  logic                    rd_do;
  logic                    rd_hit;
  logic [31:0]             rd_data;
  logic                    frozen;
  logic                    cpu_en;
  logic [wdtp_pkg::PRE_W-1:0] pre_tc;
  logic                    pre_wrap;
  logic                    osc_tick;
  logic                    step;
  logic                    underflow;

  // Write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_do         = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= wdtp_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? wdtp_pkg::RESP_OKAY : wdtp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Registers are eight bits wide; only byte lane 0 carries them
  assign wr_lane0  = wr_do && w_strb_reg[0];
  assign wr_byte   = w_data_reg[7:0];
  assign wr_start  = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_START);
  assign wr_ctrl   = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_CTRL);
  assign wr_prot   = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_PROT);
  assign wr_pm_one = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_PM_ONE) && unlock_reg;
  assign wr_pm_two = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_PM_TWO) && unlock_reg;
  assign wr_cm_one = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_CM_ONE);
  assign wr_stat   = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_IRQ_STAT);
  assign wr_mask   = wr_lane0 && (aw_addr_reg == wdtp_pkg::ADDR_IRQ_MASK);

  always_comb begin
    case (aw_addr_reg)
      wdtp_pkg::ADDR_START, wdtp_pkg::ADDR_CTRL, wdtp_pkg::ADDR_PROT,
      wdtp_pkg::ADDR_PM_ONE, wdtp_pkg::ADDR_PM_TWO, wdtp_pkg::ADDR_CM_ONE,
      wdtp_pkg::ADDR_IRQ_STAT, wdtp_pkg::ADDR_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read channel: one read at a time, data registered
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_do         = s_axi_arvalid && !rvalid_reg;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      wdtp_pkg::ADDR_START: rd_data = 32'h0000_0000;
      wdtp_pkg::ADDR_CTRL: begin
        rd_data[wdtp_pkg::CTRL_CNT_LSB +: 5]   = cnt_reg[wdtp_pkg::CNT_W-1 -: 5]; // see RL10
        rd_data[wdtp_pkg::CTRL_RSV_LSB +: 2]   = rsv_reg;
        rd_data[wdtp_pkg::CTRL_PRESEL_BIT]     = presel_reg;
      end
      wdtp_pkg::ADDR_PROT:     rd_data[wdtp_pkg::UNLOCK_BIT]    = unlock_reg;
      wdtp_pkg::ADDR_PM_ONE:   rd_data[wdtp_pkg::ACTION_BIT]    = action_reg;
      wdtp_pkg::ADDR_PM_TWO:   rd_data[wdtp_pkg::OSCSRC_BIT]    = oscsrc_reg;
      wdtp_pkg::ADDR_CM_ONE:   rd_data[wdtp_pkg::STOPREQ_BIT]   = stopreq_reg;
      wdtp_pkg::ADDR_IRQ_STAT: rd_data[wdtp_pkg::IRQ_UFLOW_BIT] = stat_reg;
      wdtp_pkg::ADDR_IRQ_MASK: rd_data[wdtp_pkg::IRQ_UFLOW_BIT] = mask_reg;
      default:                 rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= wdtp_pkg::RESP_OKAY;
    end else if (rd_do) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_data;
      rresp_reg  <= rd_hit ? wdtp_pkg::RESP_OKAY : wdtp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Software-visible configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presel_reg <= 1'b0;
      rsv_reg    <= 2'h0;
      unlock_reg <= 1'b0;
      action_reg <= 1'b0;
      oscsrc_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        presel_reg <= wr_byte[wdtp_pkg::CTRL_PRESEL_BIT];
        rsv_reg    <= wr_byte[wdtp_pkg::CTRL_RSV_LSB +: 2];
      end
      if (wr_prot) begin
        unlock_reg <= wr_byte[wdtp_pkg::UNLOCK_BIT];
      end
      if (wr_pm_one && wr_byte[wdtp_pkg::ACTION_BIT]) begin
        action_reg <= 1'b1; // see RL3
      end
      if (wr_pm_two) begin
        oscsrc_reg <= wr_byte[wdtp_pkg::OSCSRC_BIT]; // see RL14
      end
    end
  end

  // Stop request: locked out while the oscillator drives the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stopreq_reg <= 1'b0;
    end else if (wr_cm_one && !oscsrc_reg) begin
      stopreq_reg <= wr_byte[wdtp_pkg::STOPREQ_BIT]; // see RL15
    end else if (stop_wake) begin
      stopreq_reg <= 1'b0;
    end
  end

  assign stop_mode_req = stopreq_reg;
  assign osc_enable    = oscsrc_reg; // see RL14

  // Oscillator pin crosses into aclk; the second and third stages feed the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_clk_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  assign osc_tick = osc_s2_reg && !osc_s3_reg;

  // Protective mode ignores wait and hold; stop cannot be entered there
  assign frozen = !oscsrc_reg && (stopreq_reg || wait_mode || hold_state); // see RL9 see RL16
  assign cpu_en = active_reg && !frozen && cpu_clk_run;

  always_comb begin
    if (cpu_sub_clock_sel) begin
      pre_tc = wdtp_pkg::PRE_TC_2; // see RL5
    end else if (presel_reg) begin
      pre_tc = wdtp_pkg::PRE_TC_128; // see RL4
    end else begin
      pre_tc = wdtp_pkg::PRE_TC_16; // see RL4
    end
  end

  // Ratio changes mid-count give one odd period, the prescaler error software must allow
  assign pre_wrap = pre_reg >= pre_tc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= wdtp_pkg::PRE_RESET; // see RL8
    end else if (cpu_en && !oscsrc_reg) begin
      pre_reg <= pre_wrap ? wdtp_pkg::PRE_RESET : pre_reg + 7'h01; // see RL18
    end
  end

  assign step = oscsrc_reg ? (active_reg && osc_tick) : (cpu_en && pre_wrap); // see RL1 see RL11 see RL13
  assign underflow = step && (cnt_reg == wdtp_pkg::CNT_ZERO) && !wr_start;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= 1'b0; // see RL8
    end else if (wr_start) begin
      active_reg <= 1'b1; // see RL7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= wdtp_pkg::CNT_RELOAD;
    end else if (wr_start) begin
      cnt_reg <= wdtp_pkg::CNT_RELOAD; // see RL7 see RL18
    end else if (step) begin
      cnt_reg <= (cnt_reg == wdtp_pkg::CNT_ZERO) ? wdtp_pkg::CNT_RELOAD : cnt_reg - 15'h0001; // see RL6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_reset_reg <= 1'b0;
    end else begin
      wdt_reset_reg <= underflow && action_reg; // see RL2
    end
  end

  assign wdt_reset_req = wdt_reset_reg;

  // Interrupt status: set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      if (underflow && !action_reg) begin
        stat_reg <= 1'b1; // see RL2
      end else if (wr_stat && wr_byte[wdtp_pkg::IRQ_UFLOW_BIT]) begin
        stat_reg <= 1'b0;
      end
      if (wr_mask) begin
        mask_reg <= wr_byte[wdtp_pkg::IRQ_UFLOW_BIT];
      end
    end
  end

  assign irq = stat_reg && mask_reg;

  AST_START_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_start |=> (cnt_reg == wdtp_pkg::CNT_RELOAD) && active_reg) // see RL7
    else $error("start write did not reload and activate");

  AST_ACTION_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    action_reg |=> action_reg) // see RL3
    else $error("underflow action bit returned to interrupt");

  AST_DIV_MAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && !oscsrc_reg && !cpu_sub_clock_sel) |-> (pre_reg == (presel_reg ? 7'h7F : 7'h0F))) // see RL4
    else $error("main clock prescaler ratio wrong");

  AST_DIV_SUB: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_en && !oscsrc_reg && cpu_sub_clock_sel && pre_reg == 7'h00) |=> (pre_reg == 7'h01) ##0
    (!cpu_en || step)) // see RL5
    else $error("sub clock prescaler not divide by two");

  AST_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
    (frozen && !wr_start) |=> $stable(cnt_reg) && $stable(pre_reg)) // see RL9
    else $error("counter moved while frozen");

  AST_IDLE_AFTER_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    !active_reg |-> (pre_reg == 7'h00) && (cnt_reg == 15'h7FFF)) // see RL8
    else $error("watchdog counted before first start write");

  AST_UFLOW_ACTION: assert property (@(posedge aclk) disable iff (!aresetn)
    underflow |=> (wdt_reset_req == $past(action_reg)) && (stat_reg || $past(action_reg))) // see RL2
    else $error("underflow action not taken");

  AST_STOP_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    (oscsrc_reg && !stopreq_reg) |=> !stopreq_reg) // see RL15
    else $error("stop request set in protective mode");

  AST_PROT_RUNS: assert property (@(posedge aclk) disable iff (!aresetn)
    (oscsrc_reg && active_reg && osc_tick && !wr_start && cnt_reg != 15'h0000) |=>
    (cnt_reg == $past(cnt_reg) - 15'h0001)) // see RL11 see RL16
    else $error("protective mode count did not advance");

  AST_RD_CTRL: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_do && s_axi_araddr == wdtp_pkg::ADDR_CTRL) |=> (s_axi_rdata[4:0] == $past(cnt_reg[14:10]))) // see RL10
    else $error("control read lost counter bits");

  AST_STAT_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RL2
    (underflow && !action_reg) |=> stat_reg)
    else $error("underflow interrupt status not set");

  AST_STAT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // see RL2
    (wr_stat && wr_byte[0] && !(underflow && !action_reg)) |=> !stat_reg)
    else $error("interrupt status not cleared by write of one");

  AST_ACTION_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn) // see RL3
    (!unlock_reg && wr_lane0 && aw_addr_reg == wdtp_pkg::ADDR_PM_ONE) |=> (action_reg == $past(action_reg)))
    else $error("locked power mode write changed action bit");

endmodule : wdtp_core

// ---- test/wdtp_core_tb.sv ----
`timescale 1ns/1ps
module wdtp_core_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic        sub_sel, clk_run, wait_m, hold_s, wake, osc;
  logic        rst_req, irq, osc_en, stop_req;
  int          errors;
  int          n_tests;

  wdtp_core dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .cpu_sub_clock_sel(sub_sel), .cpu_clk_run(clk_run), .wait_mode(wait_m), .hold_state(hold_s),
    .stop_wake(wake), .osc_clk_in(osc),
    .wdt_reset_req(rst_req), .irq(irq), .osc_enable(osc_en), .stop_mode_req(stop_req)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic conclude;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Both channels offered together; each dropped at its own accepting edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    chk(what, exp, rd);
  endtask : rchk

  task automatic t_idle;
    sub_sel <= 1'b1;
    cyc(3000);
    rchk("idle count", wdtp_pkg::ADDR_CTRL, 32'h0000001F);
    wr(wdtp_pkg::ADDR_CTRL, 8'h80);
    rchk("prescaler select", wdtp_pkg::ADDR_CTRL, 32'h0000009F);
    wr(wdtp_pkg::ADDR_CTRL, 8'h00);
    rchk("start reads zero", wdtp_pkg::ADDR_START, 32'h00000000);
  endtask : t_idle

  task automatic t_ratio16;
    sub_sel <= 1'b0;
    wr(wdtp_pkg::ADDR_START, 8'hA5);
    cyc(16384 - 40);
    rchk("div16 before", wdtp_pkg::ADDR_CTRL, 32'h0000001F);
    cyc(80);
    rchk("div16 after", wdtp_pkg::ADDR_CTRL, 32'h0000001E);
  endtask : t_ratio16

  // A restart mid-count, then wait and hold each freeze part of the run
  task automatic t_freeze;
    sub_sel <= 1'b1;
    wr(wdtp_pkg::ADDR_START, 8'h00);
    cyc(1800);
    wr(wdtp_pkg::ADDR_START, 8'h00);
    wait_m <= 1'b1;
    cyc(1500);
    wait_m <= 1'b0;
    hold_s <= 1'b1;
    cyc(1500);
    hold_s <= 1'b0;
    cyc(2000);
    rchk("frozen count", wdtp_pkg::ADDR_CTRL, 32'h0000001F);
    cyc(100);
    rchk("resumed count", wdtp_pkg::ADDR_CTRL, 32'h0000001E);
  endtask : t_freeze

  task automatic t_underflow;
    int n;
    n = 0;
    wr(wdtp_pkg::ADDR_CTRL, 8'h80);
    wr(wdtp_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(wdtp_pkg::ADDR_START, 8'h00);
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge aclk);
      n++;
      if (rst_req !== 1'b0) chk("reset pulse", 32'h0, 32'h1);
    end
    chk("period", 32'h1, {31'h0, n >= 65530 && n <= 65545});
    wr(wdtp_pkg::ADDR_IRQ_MASK, 8'h00);
    chk("masked irq", 32'h0, {31'h0, irq});
    rchk("status", wdtp_pkg::ADDR_IRQ_STAT, 32'h00000001);
    wr(wdtp_pkg::ADDR_IRQ_MASK, 8'h01);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    wr(wdtp_pkg::ADDR_IRQ_STAT, 8'h01);
    chk("cleared irq", 32'h0, {31'h0, irq});
  endtask : t_underflow

  task automatic t_regs;
    wr(wdtp_pkg::ADDR_PM_ONE, 8'h04);
    rdr(wdtp_pkg::ADDR_PM_ONE);
    chk("locked action", 32'h0, rd & 32'h4);
    wr(wdtp_pkg::ADDR_PROT, 8'h02);
    wr(wdtp_pkg::ADDR_PM_ONE, 8'h04);
    wr(wdtp_pkg::ADDR_PM_ONE, 8'h00);
    rdr(wdtp_pkg::ADDR_PM_ONE);
    chk("action set only", 32'h4, rd & 32'h4);
    wr(wdtp_pkg::ADDR_CM_ONE, 8'h01);
    chk("stop request", 32'h1, {31'h0, stop_req});
    @(posedge aclk);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    cyc(2);
    chk("stop woken", 32'h0, {31'h0, stop_req});
    wr(wdtp_pkg::ADDR_PM_TWO, 8'h04);
    chk("osc enable", 32'h1, {31'h0, osc_en});
    wr(wdtp_pkg::ADDR_PROT, 8'h00);
    wr(wdtp_pkg::ADDR_CM_ONE, 8'h01);
    chk("stop ignored", 32'h0, {31'h0, stop_req});
    rdr(wdtp_pkg::ADDR_CM_ONE);
    chk("stop bit", 32'h0, rd & 32'h1);
    rdr(8'hFC);
    chk("unmapped", {30'h0, wdtp_pkg::RESP_SLVERR}, {30'h0, rs});
  endtask : t_regs

  // Oscillator runs only here; CPU clock halted and wait asserted throughout
  task automatic t_protect;
    wr(wdtp_pkg::ADDR_START, 8'h00);
    clk_run <= 1'b0;
    wait_m  <= 1'b1;
    repeat (2200) begin
      cyc(2);
      osc <= ~osc;
    end
    cyc(8);
    rchk("osc count", wdtp_pkg::ADDR_CTRL, 32'h0000009E);
    chk("no reset yet", 32'h0, {31'h0, rst_req});
  endtask : t_protect

  initial begin
    repeat (99000) @(posedge aclk);
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    {sub_sel, wait_m, hold_s, wake, osc} = 5'h00;
    clk_run = 1'b1;
    cyc(5);
    aresetn <= 1'b1;
    t_idle();
    t_ratio16();
    t_freeze();
    t_underflow();
    t_regs();
    t_protect();
    conclude();
  end
endmodule : wdtp_core_tb
